// *** design/timer0_split_mode_control.sv ***
`timescale 1ns/1ps
// Summary of operation
// RULE1 - Mode 3 on the first timer splits it into two 8-bit counters.
// RULE2 - Low byte uses first timer run, select, gate and overflow flag.
// RULE3 - Low byte counts clock ticks or falling edges of the count pin.
// RULE4 - High byte is a timer only, system or prescaled clock.
// RULE5 - High byte advances only while second timer run is set; no gate.
// RULE6 - High byte wrap sets second timer overflow flag and its request.
// RULE7 - Second timer in split mode: no pin counting, no flag, no interrupt.
// RULE8 - Second timer overflow still gives the baud and conversion tick.
// RULE9 - In split mode second timer runs in modes 0-2, stops in mode 3.
// RULE10 - Each external interrupt has level/edge select and polarity bit.
// RULE11 - Counter overflow sets its flag and requests its interrupt.
// RULE12 - Run enables timer if gate clear, or gate set and input active.
// RULE13 - Setting run does not reset the count.
// RULE14 - Flags set by hardware, cleared by software or by vectoring.
// RULE15 - Level-sensed external flag follows the active input.
module timer0_split_mode_control #(
  parameter int PRESCALE = timer0_split_pkg::PRESCALE_DIV
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        first_count_pin,
  input  wire logic        second_count_pin,
  input  wire logic        ext_irq0_input,
  input  wire logic        ext_irq1_input,
  input  wire logic [3:0]  vecAck,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             irq,
  output logic             timer0Request,
  output logic             timer1Request,
  output logic             ext0Request,
  output logic             ext1Request,
  output logic             timer1OverflowTick
);

  typedef struct packed {
    logic [7:0]  tcs;
    logic [7:0]  mode;
    logic [7:0]  cnt0Lo;
    logic [7:0]  cnt0Hi;
    logic [7:0]  cnt1Lo;
    logic [7:0]  cnt1Hi;
    logic [7:0]  cfg;
    logic [3:0]  istat;
    logic [3:0]  imask;
    logic [3:0]  sync1;
    logic [3:0]  sync2;
    logic [3:0]  prev;
    logic [7:0]  pre;
    logic        awRdy;
    logic        awHeld;
    logic [7:0]  awAddr;
    logic        wRdy;
    logic        wHeld;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bValid;
    logic [1:0]  bResp;
    logic        arRdy;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;
    logic        irq;
    logic        wrapTick;
  } state_t;

  state_t s_q;
  state_t s_d;

  function automatic logic [7:0] wordAddr(input logic [7:0] a);
    wordAddr = {a[7:2], 2'b00};
  endfunction

  function automatic logic addrHit(input logic [7:0] a);
    logic [7:0] w;
    w = wordAddr(a);
    addrHit = (w == timer0_split_pkg::ADDR_TCS) || (w == timer0_split_pkg::ADDR_MODE)
           || (w == timer0_split_pkg::ADDR_CNT0_LO) || (w == timer0_split_pkg::ADDR_CNT0_HI)
           || (w == timer0_split_pkg::ADDR_CNT1_LO) || (w == timer0_split_pkg::ADDR_CNT1_HI)
           || (w == timer0_split_pkg::ADDR_CFG) || (w == timer0_split_pkg::ADDR_ISTAT)
           || (w == timer0_split_pkg::ADDR_IMASK);
  endfunction

  // One count step in modes 0 to 2; returns {overflow, high, low}
  function automatic logic [16:0] advance(input logic [1:0] m,
                                          input logic [7:0] lo,
                                          input logic [7:0] hi);
    logic [13:0] v13;
    logic [16:0] v16;
    logic [8:0]  v8;
    v13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    v16 = {1'b0, hi, lo} + 17'h00001;
    v8  = {1'b0, lo} + 9'h001;
    case (m)
      timer0_split_pkg::MODE_13BIT: advance = {v13[13], v13[12:5], lo[7:5], v13[4:0]};
      timer0_split_pkg::MODE_16BIT: advance = v16;
      timer0_split_pkg::MODE_8RELOAD: advance = {v8[8], hi, (v8[8] ? hi : v8[7:0])};
      default: advance = {1'b0, hi, lo};
    endcase
  endfunction

  logic        preTick;
  logic [3:0]  fall;
  logic        act0;
  logic        act1;
  logic        act0Prev;
  logic        act1Prev;
  logic        tick0;
  logic        tick1;
  logic        step0;
  logic        step1;
  logic        split;
  logic        ovf0Set;
  logic        ovf1Set;
  logic        cnt1Wrap;
  logic        doWrite;
  logic        wrByte;
  logic [7:0]  wrAddr;
  logic [7:0]  wrVal;
  logic [8:0]  sum8;
  logic [16:0] adv;
  logic [3:0]  ev;
  logic [3:0]  w1c;
  logic [7:0]  rdAddr;

  always_comb begin
    s_d = s_q;
    s_d.wrapTick = 1'b0;
    sum8 = 9'h000;
    adv = 17'h00000;
    ovf0Set = 1'b0;
    ovf1Set = 1'b0;
    cnt1Wrap = 1'b0;
    w1c = 4'h0;

    // Prescaler and pin synchronisers
    preTick = (s_q.pre == 8'(PRESCALE - 1));
    s_d.pre = preTick ? 8'h00 : s_q.pre + 8'h01;
    s_d.sync1 = {ext_irq1_input, ext_irq0_input, second_count_pin, first_count_pin};
    s_d.sync2 = s_q.sync1;
    s_d.prev = s_q.sync2;
    fall = s_q.prev & ~s_q.sync2;

    act0 = (s_q.sync2[timer0_split_pkg::PIN_EXT0] == s_q.cfg[timer0_split_pkg::CFG_POL0]); // [RULE10]
    act1 = (s_q.sync2[timer0_split_pkg::PIN_EXT1] == s_q.cfg[timer0_split_pkg::CFG_POL1]); // [RULE10]
    act0Prev = (s_q.prev[timer0_split_pkg::PIN_EXT0] == s_q.cfg[timer0_split_pkg::CFG_POL0]);
    act1Prev = (s_q.prev[timer0_split_pkg::PIN_EXT1] == s_q.cfg[timer0_split_pkg::CFG_POL1]);
    tick0 = s_q.cfg[timer0_split_pkg::CFG_SYS0] | preTick;
    tick1 = s_q.cfg[timer0_split_pkg::CFG_SYS1] | preTick;

    split = (s_q.mode[timer0_split_pkg::MODE_M0_HI:timer0_split_pkg::MODE_M0_LO]
             == timer0_split_pkg::MODE_SPLIT);

    // First timer enable and step source
    step0 = s_q.tcs[timer0_split_pkg::TCS_RUN0]
          && (!s_q.mode[timer0_split_pkg::MODE_GATE_PRI] || act0) // [RULE12] [RULE2]
          && (s_q.mode[timer0_split_pkg::MODE_CT0] ? fall[timer0_split_pkg::PIN_CNT0]
                                                   : tick0);  // [RULE3]

    if (split) begin
      // Low byte, 8-bit wrap
      if (step0) begin
        sum8 = {1'b0, s_q.cnt0Lo} + 9'h001; // [RULE1] [RULE13]
        s_d.cnt0Lo = sum8[7:0];
        ovf0Set = sum8[8]; // [RULE2]
      end
      // High byte, timer only, run by second timer run bit
      if (s_q.tcs[timer0_split_pkg::TCS_RUN1] && tick0) begin // [RULE4] [RULE5]
        sum8 = {1'b0, s_q.cnt0Hi} + 9'h001; // [RULE1]
        s_d.cnt0Hi = sum8[7:0];
        ovf1Set = sum8[8]; // [RULE6]
      end
      // Second timer: mode decides, internal clock only, no flag
      step1 = (s_q.mode[timer0_split_pkg::MODE_M1_HI:timer0_split_pkg::MODE_M1_LO]
               != timer0_split_pkg::MODE_SPLIT) && tick1; // [RULE9] [RULE7]
      if (step1) begin
        adv = advance(s_q.mode[timer0_split_pkg::MODE_M1_HI:timer0_split_pkg::MODE_M1_LO],
                      s_q.cnt1Lo, s_q.cnt1Hi);
        s_d.cnt1Lo = adv[7:0];
        s_d.cnt1Hi = adv[15:8];
        cnt1Wrap = adv[16];
      end
    end else begin
      if (step0) begin
        adv = advance(s_q.mode[timer0_split_pkg::MODE_M0_HI:timer0_split_pkg::MODE_M0_LO],
                      s_q.cnt0Lo, s_q.cnt0Hi); // [RULE13]
        s_d.cnt0Lo = adv[7:0];
        s_d.cnt0Hi = adv[15:8];
        ovf0Set = adv[16]; // [RULE11]
      end
      step1 = s_q.tcs[timer0_split_pkg::TCS_RUN1]
            && (!s_q.mode[timer0_split_pkg::MODE_GATE_SEC] || act1) // [RULE12]
            && (s_q.mode[timer0_split_pkg::MODE_M1_HI:timer0_split_pkg::MODE_M1_LO]
                != timer0_split_pkg::MODE_SPLIT)
            && (s_q.mode[timer0_split_pkg::MODE_CT1] ? fall[timer0_split_pkg::PIN_CNT1]
                                                     : tick1);
      if (step1) begin
        adv = advance(s_q.mode[timer0_split_pkg::MODE_M1_HI:timer0_split_pkg::MODE_M1_LO],
                      s_q.cnt1Lo, s_q.cnt1Hi);
        s_d.cnt1Lo = adv[7:0];
        s_d.cnt1Hi = adv[15:8];
        cnt1Wrap = adv[16];
        ovf1Set = adv[16]; // [RULE11]
      end
    end
    s_d.wrapTick = cnt1Wrap; // [RULE8]

    // Write channel capture
    if (s_axi_awvalid && s_q.awRdy) begin
      s_d.awHeld = 1'b1;
      s_d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wRdy) begin
      s_d.wHeld = 1'b1;
      s_d.wData = s_axi_wdata;
      s_d.wStrb = s_axi_wstrb;
    end
    if (s_axi_bready && s_q.bValid) begin
      s_d.bValid = 1'b0;
    end
    doWrite = s_q.awHeld && s_q.wHeld && !s_q.bValid;
    wrAddr = wordAddr(s_q.awAddr);
    wrByte = doWrite && s_q.wStrb[0];
    wrVal = s_q.wData[7:0];
    if (doWrite) begin
      s_d.awHeld = 1'b0;
      s_d.wHeld = 1'b0;
      s_d.bValid = 1'b1;
      s_d.bResp = addrHit(s_q.awAddr) ? timer0_split_pkg::RESP_OKAY
                                      : timer0_split_pkg::RESP_SLVERR;
    end

    // Software writes; counter loads override a count step
    if (wrByte) begin
      case (wrAddr)
        timer0_split_pkg::ADDR_TCS:   s_d.tcs = wrVal;
        timer0_split_pkg::ADDR_MODE:  s_d.mode = wrVal;
        timer0_split_pkg::ADDR_CNT0_LO: s_d.cnt0Lo = wrVal;
        timer0_split_pkg::ADDR_CNT0_HI: s_d.cnt0Hi = wrVal;
        timer0_split_pkg::ADDR_CNT1_LO: s_d.cnt1Lo = wrVal;
        timer0_split_pkg::ADDR_CNT1_HI: s_d.cnt1Hi = wrVal;
        timer0_split_pkg::ADDR_CFG:   s_d.cfg = wrVal;
        timer0_split_pkg::ADDR_ISTAT: w1c = wrVal[3:0];
        timer0_split_pkg::ADDR_IMASK: s_d.imask = wrVal[3:0];
        default: ;
      endcase
    end

    // Flag clear by vectoring, then hardware set wins
    s_d.tcs[timer0_split_pkg::TCS_OVF0] = (s_d.tcs[timer0_split_pkg::TCS_OVF0]
        & ~vecAck[timer0_split_pkg::EV_OVF0]) | ovf0Set; // [RULE14]
    s_d.tcs[timer0_split_pkg::TCS_OVF1] = (s_d.tcs[timer0_split_pkg::TCS_OVF1]
        & ~vecAck[timer0_split_pkg::EV_OVF1]) | ovf1Set; // [RULE14]
    if (s_q.tcs[timer0_split_pkg::TCS_XTYPE0]) begin
      s_d.tcs[timer0_split_pkg::TCS_XFLAG0] = (s_d.tcs[timer0_split_pkg::TCS_XFLAG0]
          & ~vecAck[timer0_split_pkg::EV_XINT0])
          | (act0 & ~act0Prev); // [RULE14] [RULE10]
    end else begin
      s_d.tcs[timer0_split_pkg::TCS_XFLAG0] = act0; // [RULE15]
    end
    if (s_q.tcs[timer0_split_pkg::TCS_XTYPE1]) begin
      s_d.tcs[timer0_split_pkg::TCS_XFLAG1] = (s_d.tcs[timer0_split_pkg::TCS_XFLAG1]
          & ~vecAck[timer0_split_pkg::EV_XINT1])
          | (act1 & ~act1Prev); // [RULE14] [RULE10]
    end else begin
      s_d.tcs[timer0_split_pkg::TCS_XFLAG1] = act1; // [RULE15]
    end

    // Sticky events, write one to clear, set wins
    ev = {act1 & ~act1Prev, act0 & ~act0Prev, ovf1Set, ovf0Set};
    s_d.istat = (s_q.istat & ~w1c) | ev;
    s_d.irq = |(s_d.istat & s_d.imask);

    // Read channel
    if (s_axi_rready && s_q.rValid) begin
      s_d.rValid = 1'b0;
    end
    rdAddr = wordAddr(s_axi_araddr);
    if (s_axi_arvalid && s_q.arRdy) begin
      s_d.rValid = 1'b1;
      s_d.rResp = addrHit(s_axi_araddr) ? timer0_split_pkg::RESP_OKAY
                                        : timer0_split_pkg::RESP_SLVERR;
      case (rdAddr)
        timer0_split_pkg::ADDR_TCS:   s_d.rData = {24'h000000, s_q.tcs};
        timer0_split_pkg::ADDR_MODE:  s_d.rData = {24'h000000, s_q.mode};
        timer0_split_pkg::ADDR_CNT0_LO: s_d.rData = {24'h000000, s_q.cnt0Lo};
        timer0_split_pkg::ADDR_CNT0_HI: s_d.rData = {24'h000000, s_q.cnt0Hi};
        timer0_split_pkg::ADDR_CNT1_LO: s_d.rData = {24'h000000, s_q.cnt1Lo};
        timer0_split_pkg::ADDR_CNT1_HI: s_d.rData = {24'h000000, s_q.cnt1Hi};
        timer0_split_pkg::ADDR_CFG:   s_d.rData = {24'h000000, s_q.cfg};
        timer0_split_pkg::ADDR_ISTAT: s_d.rData = {28'h0000000, s_q.istat};
        timer0_split_pkg::ADDR_IMASK: s_d.rData = {28'h0000000, s_q.imask};
        default:                      s_d.rData = 32'h00000000;
      endcase
    end

    s_d.awRdy = !s_d.awHeld;
    s_d.wRdy = !s_d.wHeld;
    s_d.arRdy = !s_d.rValid;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.awRdy;
  assign s_axi_wready = s_q.wRdy;
  assign s_axi_bvalid = s_q.bValid;
  assign s_axi_bresp = s_q.bResp;
  assign s_axi_arready = s_q.arRdy;
  assign s_axi_rvalid = s_q.rValid;
  assign s_axi_rdata = s_q.rData;
  assign s_axi_rresp = s_q.rResp;
  assign irq = s_q.irq;
  assign timer0Request = s_q.tcs[timer0_split_pkg::TCS_OVF0];
  assign timer1Request = s_q.tcs[timer0_split_pkg::TCS_OVF1];
  assign ext0Request = s_q.tcs[timer0_split_pkg::TCS_XFLAG0];
  assign ext1Request = s_q.tcs[timer0_split_pkg::TCS_XFLAG1];
  assign timer1OverflowTick = s_q.wrapTick;

endmodule

// *** design/timer0_split_pkg.sv ***
package timer0_split_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_TCS   = 8'h88;
  localparam logic [7:0] ADDR_MODE  = 8'h8c;
  localparam logic [7:0] ADDR_CNT0_LO = 8'h90;
  localparam logic [7:0] ADDR_CNT0_HI = 8'h94;
  localparam logic [7:0] ADDR_CNT1_LO = 8'h98;
  localparam logic [7:0] ADDR_CNT1_HI = 8'h9c;
  localparam logic [7:0] ADDR_CFG   = 8'ha0;
  localparam logic [7:0] ADDR_ISTAT = 8'ha4;
  localparam logic [7:0] ADDR_IMASK = 8'ha8;

  // timer_control_status fields
  localparam int TCS_OVF1   = 7;
  localparam int TCS_RUN1   = 6;
  localparam int TCS_OVF0   = 5;
  localparam int TCS_RUN0   = 4;
  localparam int TCS_XFLAG1 = 3;
  localparam int TCS_XTYPE1 = 2;
  localparam int TCS_XFLAG0 = 1;
  localparam int TCS_XTYPE0 = 0;
  localparam logic [7:0] TCS_RESET = 8'h00;

  // timer_mode_select_reg fields
  localparam int MODE_GATE_SEC = 7;
  localparam int MODE_CT1   = 6;
  localparam int MODE_M1_HI = 5;
  localparam int MODE_M1_LO = 4;
  localparam int MODE_GATE_PRI = 3;
  localparam int MODE_CT0   = 2;
  localparam int MODE_M0_HI = 1;
  localparam int MODE_M0_LO = 0;
  localparam logic [7:0] MODE_RESET = 8'h00;

  // Configuration fields
  localparam int CFG_POL0 = 0;
  localparam int CFG_POL1 = 1;
  localparam int CFG_SYS0 = 2;
  localparam int CFG_SYS1 = 3;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // Interrupt status / mask bits and synchroniser slots
  localparam int EV_OVF0  = 0;
  localparam int EV_OVF1  = 1;
  localparam int EV_XINT0 = 2;
  localparam int EV_XINT1 = 3;
  localparam int PIN_CNT0 = 0;
  localparam int PIN_CNT1 = 1;
  localparam int PIN_EXT0 = 2;
  localparam int PIN_EXT1 = 3;

  localparam logic [1:0] MODE_13BIT = 2'h0;
  localparam logic [1:0] MODE_16BIT = 2'h1;
  localparam logic [1:0] MODE_8RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int PRESCALE_DIV = 12;
endpackage

// *** bench/timer0_split_monitor.sv ***
`timescale 1ns/1ps
module timer0_split_monitor #(
  parameter int PRESCALE = 12
) (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  sequence awTaken;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence wTaken;
    s_axi_wvalid && s_axi_wready;
  endsequence
  sequence arTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (awTaken ##0 wTaken |-> ##2 s_axi_bvalid)
    else $error("write not answered");
  a_read_answer: assert property (arTaken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_aw_refuse: assert property (awTaken |=> !s_axi_awready)
    else $error("address taken twice");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address open while busy");
  a_reset_quiet: assert property ($rose(rst_n) |->
    !s_axi_awready && !s_axi_arready && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active after reset");
endmodule

bind timer0_split_mode_control timer0_split_monitor #(.PRESCALE(PRESCALE)) u_monitor (
  .clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));

// *** bench/timer0_split_mode_control_tb.sv ***
`timescale 1ns/1ps
module timer0_split_mode_control_tb;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        cntPin = 1'b1;
  logic        extIn = 1'b1;
  logic        ext1In = 1'b1;
  logic [3:0]  vecAck = 4'h0;
  logic        awValid = 1'b0;
  logic        wValid = 1'b0;
  logic        bReady = 1'b0;
  logic        arValid = 1'b0;
  logic        rReady = 1'b0;
  logic [7:0]  awAddr = 8'h00;
  logic [7:0]  arAddr = 8'h00;
  logic [31:0] wData = 32'h0;
  logic        awReady, wReady, bValid, arReady, rValid, irq, ovf0Req, ovf1Req, e0Req, e1Req;
  logic        tick;
  logic [1:0]  bResp, rResp;
  logic [31:0] rData, v, a;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          nTick = 0;

  timer0_split_mode_control #(.PRESCALE(2)) u_timer0_split_mode_control (
    .clk_sys(clk_sys), .rst_n(rst_n), .first_count_pin(cntPin), .second_count_pin(1'b1),
    .ext_irq0_input(extIn), .ext_irq1_input(ext1In), .vecAck(vecAck),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_awaddr(awAddr),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_wdata(wData),
    .s_axi_wstrb(4'hf), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_bresp(bResp), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_araddr(arAddr), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .irq(irq), .timer0Request(ovf0Req),
    .timer1Request(ovf1Req), .ext0Request(e0Req), .ext1Request(e1Req),
    .timer1OverflowTick(tick));

  always #2.5 clk_sys = ~clk_sys;

  // Overflow tick counter and hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (tick === 1'b1) begin
      nTick++;
    end
    if (cycles == 6000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic waitCyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Late bready and rready exercise the response hold
  task automatic wr(input logic [7:0] ad, input logic [7:0] d, input logic [1:0] er);
    logic awDone;
    logic wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    awAddr <= ad;
    wData <= {24'h0, d};
    awValid <= 1'b1;
    wValid <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge clk_sys);
      if (awValid && awReady) begin
        awDone = 1'b1;
        awValid <= 1'b0;
      end
      if (wValid && wReady) begin
        wDone = 1'b1;
        wValid <= 1'b0;
      end
    end
    waitCyc(2);
    bReady <= 1'b1;
    do @(posedge clk_sys); while (bValid !== 1'b1);
    bReady <= 1'b0;
    chk("bresp", 32'(bResp), 32'(er));
  endtask

  task automatic rd(input logic [7:0] ad, input logic [1:0] er);
    arAddr <= ad;
    arValid <= 1'b1;
    do @(posedge clk_sys); while (arReady !== 1'b1);
    arValid <= 1'b0;
    waitCyc(2);
    rReady <= 1'b1;
    do @(posedge clk_sys); while (rValid !== 1'b1);
    rReady <= 1'b0;
    v = rData;
    chk("rresp", 32'(rResp), 32'(er));
  endtask

  task automatic ack(input logic [3:0] m);
    vecAck <= m;
    @(posedge clk_sys);
    vecAck <= 4'h0;
    waitCyc(3);
  endtask

  initial begin
    waitCyc(12);
    rst_n <= 1'b1;
    // Let the pin synchronisers settle to the idle level
    waitCyc(4);
    rd(8'h88, 2'h0);
    chk("tcs reset", v, 32'h0);
    rd(8'h00, 2'h2);
    chk("unmapped read", v, 32'h0);
    wr(8'h00, 8'h5a, 2'h2);
    wr(8'ha0, 8'h0c, 2'h0);
    wr(8'h8c, 8'h33, 2'h0);
    wr(8'h90, 8'hf0, 2'h0);
    wr(8'h94, 8'h80, 2'h0);
    wr(8'h88, 8'h10, 2'h0);
    waitCyc(40);
    rd(8'h88, 2'h0);
    chk("ovf0 set", v, 32'h30);
    chk("ovf0 request", 32'(ovf0Req), 32'h1);
    rd(8'h94, 2'h0);
    chk("high byte idle", v, 32'h80);
    // Gate with active high input
    extIn <= 1'b0;
    wr(8'h8c, 8'h3b, 2'h0);
    wr(8'ha0, 8'h0d, 2'h0);
    wr(8'h88, 8'h10, 2'h0);
    rd(8'h90, 2'h0);
    a = v;
    waitCyc(10);
    rd(8'h90, 2'h0);
    chk("gated off", v, a);
    extIn <= 1'b1;
    waitCyc(6);
    chk("level flag", 32'(e0Req), 32'h1);
    rd(8'h90, 2'h0);
    chk("gated on", 32'(v == a), 32'h0);
    extIn <= 1'b0;
    waitCyc(6);
    chk("level drop", 32'(e0Req), 32'h0);
    chk("level idle 1", 32'(e1Req), 32'h0);
    ext1In <= 1'b0;
    waitCyc(6);
    chk("level flag 1", 32'(e1Req), 32'h1);
    ext1In <= 1'b1;
    waitCyc(6);
    chk("level drop 1", 32'(e1Req), 32'h0);
    // High byte on second run bit
    wr(8'h88, 8'h00, 2'h0);
    wr(8'h94, 8'hf0, 2'h0);
    rd(8'h90, 2'h0);
    a = v;
    wr(8'h88, 8'h40, 2'h0);
    waitCyc(30);
    chk("ovf1 request", 32'(ovf1Req), 32'h1);
    rd(8'h88, 2'h0);
    chk("ovf1 from high", v, 32'hc0);
    rd(8'h90, 2'h0);
    chk("low byte held", v, a);
    wr(8'h88, 8'h80, 2'h0);
    ack(4'h2);
    chk("ovf1 vectored", 32'(ovf1Req), 32'h0);
    // Second timer in mode 2, then mode 3
    wr(8'h9c, 8'hfe, 2'h0);
    wr(8'h98, 8'hfe, 2'h0);
    // Counter select set: pin must be ignored in split mode
    wr(8'h8c, 8'h63, 2'h0);
    nTick = 0;
    waitCyc(40);
    chk("tick seen", 32'(nTick > 0), 32'h1);
    rd(8'h88, 2'h0);
    chk("ovf1 quiet", v, 32'h0);
    wr(8'h8c, 8'h33, 2'h0);
    waitCyc(4);
    nTick = 0;
    rd(8'h98, 2'h0);
    a = v;
    waitCyc(20);
    rd(8'h98, 2'h0);
    chk("second timer stopped", v, a);
    chk("no tick", 32'(nTick), 32'h0);
    // Low byte counts pin falls from a preload
    wr(8'h8c, 8'h37, 2'h0);
    wr(8'h90, 8'h10, 2'h0);
    wr(8'h88, 8'h10, 2'h0);
    repeat (5) begin
      cntPin <= 1'b0;
      waitCyc(4);
      cntPin <= 1'b1;
      waitCyc(4);
    end
    waitCyc(6);
    rd(8'h90, 2'h0);
    chk("pin count", v, 32'h15);
    wr(8'h88, 8'h00, 2'h0);
    chk("irq masked", 32'(irq), 32'h0);
    wr(8'ha8, 8'h01, 2'h0);
    waitCyc(3);
    chk("irq on", 32'(irq), 32'h1);
    wr(8'ha4, 8'h0f, 2'h0);
    waitCyc(3);
    chk("irq off", 32'(irq), 32'h0);
    // Edge sensing, active low
    wr(8'ha0, 8'h0c, 2'h0);
    extIn <= 1'b1;
    wr(8'h88, 8'h01, 2'h0);
    wr(8'ha4, 8'h0f, 2'h0);
    wr(8'ha8, 8'h04, 2'h0);
    extIn <= 1'b0;
    waitCyc(3);
    extIn <= 1'b1;
    waitCyc(6);
    chk("edge latched", 32'(e0Req), 32'h1);
    chk("irq edge", 32'(irq), 32'h1);
    ack(4'h4);
    chk("edge vectored", 32'(e0Req), 32'h0);
    stop_test();
  end
endmodule
